// >>> design/xbrc_route_ctrl.sv
// route selection, interface selection, transceiver wake and preemphasis control
module xbrc_route_ctrl #(
   parameter int IDLE_TIMEOUT = xbrc_pkg::IDLE_TIMEOUT_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic small_variant,
   input wire logic interface_select_pin,
   input wire logic [5:0] route_pin_high,
   input wire logic [5:0] route_pin_low,
   input wire logic pd_pin_high,
   input wire logic pd_pin_low,
   input wire logic route_wr,
   input wire logic [2:0] route_wr_out0,
   input wire logic [2:0] route_wr_out1,
   input wire logic [2:0] route_wr_out2,
   input wire logic preemph_wr,
   input wire logic preemph_wr_val,
   input wire logic sleep_cmd,
   input wire logic lin_rxd,
   input wire logic lin_txd_in,
   output logic lin_mode,
   output logic [2:0] out_port_0_sel,
   output logic [2:0] out_port_1_sel,
   output logic [2:0] out_port_2_sel,
   output logic preemph_en,
   output logic powerdown,
   output logic transceiver_sleep_n,
   output logic lin_txd,
   output logic lin_txd_oe_n
);
   logic [1:0] rlev [xbrc_pkg::NUM_ROUTE_PINS];
   logic [1:0] pd_lev;
   genvar gi;
   generate
      for (gi = 0; gi < xbrc_pkg::NUM_ROUTE_PINS; gi++) begin : g_pin
         xbrc_tri_decode u_dec (
            .mclk(mclk),
            .rst(rst),
            .pin_high(route_pin_high[gi]),
            .pin_low(route_pin_low[gi]),
            .level(rlev[gi])
         );
      end
   endgenerate
   xbrc_tri_decode u_pd_dec (
      .mclk(mclk),
      .rst(rst),
      .pin_high(pd_pin_high),
      .pin_low(pd_pin_low),
      .level(pd_lev)
   );

   // decoded value valid one cycle after reset release; latch on the second
   logic [1:0] boot_cnt_reg;
   wire logic boot_done;
   wire logic boot_latch;
   assign boot_done = (boot_cnt_reg == 2'h2);
   assign boot_latch = (boot_cnt_reg == 2'h1);
   always_ff @(posedge mclk) begin
      if (rst) begin
         boot_cnt_reg <= 2'h0;
      end else if (!boot_done) begin
         boot_cnt_reg <= boot_cnt_reg + 2'h1;
      end
   end

   // per-output decode of a bank pin and a data pin
   function automatic logic [2:0] pick(input logic [1:0] bank, input logic [1:0] dat);
      logic [2:0] r;
      r = xbrc_pkg::SEL_HIZ;
      if (bank == xbrc_pkg::LVL_LOW) begin
         r = (dat == xbrc_pkg::LVL_LOW) ? xbrc_pkg::SEL_IN0 :
             (dat == xbrc_pkg::LVL_MID) ? xbrc_pkg::SEL_IN1 : xbrc_pkg::SEL_IN2;
      end else if (bank == xbrc_pkg::LVL_HIGH) begin
         // bank high with data high is undefined; held at high impedance
         r = (dat == xbrc_pkg::LVL_LOW) ? xbrc_pkg::SEL_IN3 : xbrc_pkg::SEL_HIZ;
      end
      return r;
   endfunction

   wire logic [2:0] pin_sel0;
   wire logic [2:0] pin_sel1;
   wire logic [2:0] pin_sel2;
   wire logic all_mid;
   assign pin_sel0 = pick(rlev[5], rlev[0]);
   assign pin_sel1 = pick(rlev[4], rlev[1]);
   assign pin_sel2 = pick(rlev[3], rlev[2]);
   assign all_mid = (rlev[0] == xbrc_pkg::LVL_MID) && (rlev[1] == xbrc_pkg::LVL_MID) &&
                    (rlev[2] == xbrc_pkg::LVL_MID) && (rlev[3] == xbrc_pkg::LVL_MID) &&
                    (rlev[4] == xbrc_pkg::LVL_MID) && (rlev[5] == xbrc_pkg::LVL_MID);

   // routing and interface mode registers
   logic lin_mode_reg;
   logic [2:0] sel0_reg;
   logic [2:0] sel1_reg;
   logic [2:0] sel2_reg;
   wire logic lin_mode_next;
   assign lin_mode_next = small_variant ? interface_select_pin : all_mid;
   always_ff @(posedge mclk) begin
      if (rst) begin
         lin_mode_reg <= 1'b0;
         sel0_reg <= xbrc_pkg::SEL_HIZ;
         sel1_reg <= xbrc_pkg::SEL_HIZ;
         sel2_reg <= xbrc_pkg::SEL_HIZ;
      end else if (boot_latch) begin
         lin_mode_reg <= lin_mode_next;
         if (!small_variant && !all_mid) begin
            sel0_reg <= pin_sel0;
            sel1_reg <= pin_sel1;
            sel2_reg <= pin_sel2;
         end
      end else if (route_wr && boot_done) begin
         // writes are accepted in power-down too; state simply persists
         sel0_reg <= route_wr_out0;
         sel1_reg <= route_wr_out1;
         sel2_reg <= route_wr_out2;
      end
   end
   assign lin_mode = lin_mode_reg;
   assign out_port_0_sel = sel0_reg;
   assign out_port_1_sel = sel1_reg;
   assign out_port_2_sel = sel2_reg;

   // preemphasis setting and power-down; the pd pin never clears registers
   logic preemph_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         preemph_reg <= 1'b0;
      end else if (preemph_wr) begin
         preemph_reg <= preemph_wr_val;
      end
   end
   logic preemph_out_reg;
   logic powerdown_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         preemph_out_reg <= 1'b0;
         powerdown_reg <= 1'b0;
      end else begin
         preemph_out_reg <= (pd_lev == xbrc_pkg::LVL_MID) |
                            ((pd_lev == xbrc_pkg::LVL_HIGH) & preemph_reg);
         powerdown_reg <= (pd_lev == xbrc_pkg::LVL_LOW);
      end
   end
   assign preemph_en = preemph_out_reg;
   assign powerdown = powerdown_reg;

   // transceiver wake / sleep
   xbrc_pkg::xbrc_lin_state_t st_reg;
   xbrc_pkg::xbrc_lin_state_t st_next;
   logic rxd_d_reg;
   logic [xbrc_pkg::IDLE_CNT_W-1:0] idle_reg;
   logic transceiver_sleep_n_reg;
   logic txd_en_reg;
   wire logic rxd_fall;
   wire logic rxd_edge;
   wire logic idle_out;
   assign rxd_fall = rxd_d_reg & ~lin_rxd;
   assign rxd_edge = rxd_d_reg ^ lin_rxd;
   assign idle_out = (idle_reg == IDLE_TIMEOUT[xbrc_pkg::IDLE_CNT_W-1:0]);
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         xbrc_pkg::XBRC_LIN_SLEEP: begin
            if (lin_mode_reg && rxd_fall) begin
               st_next = xbrc_pkg::XBRC_LIN_WAKE;
            end
         end
         xbrc_pkg::XBRC_LIN_WAKE: begin
            st_next = xbrc_pkg::XBRC_LIN_ACTIVE;
         end
         xbrc_pkg::XBRC_LIN_ACTIVE: begin
            if (sleep_cmd || idle_out || !lin_mode_reg) begin
               st_next = xbrc_pkg::XBRC_LIN_SLEEP;
            end
         end
         default: begin
            st_next = xbrc_pkg::XBRC_LIN_SLEEP;
         end
      endcase
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= xbrc_pkg::XBRC_LIN_SLEEP;
         rxd_d_reg <= 1'b1;
         transceiver_sleep_n_reg <= 1'b0;
         txd_en_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         rxd_d_reg <= lin_rxd;
         transceiver_sleep_n_reg <= (st_next != xbrc_pkg::XBRC_LIN_SLEEP);
         txd_en_reg <= (st_next == xbrc_pkg::XBRC_LIN_ACTIVE);
      end
   end
   always_ff @(posedge mclk) begin
      if (rst || rxd_edge || st_reg != xbrc_pkg::XBRC_LIN_ACTIVE) begin
         idle_reg <= '0;
      end else if (!idle_out) begin
         idle_reg <= idle_reg + 1'b1;
      end
   end
   assign transceiver_sleep_n = transceiver_sleep_n_reg;
   // recessive high while not enabled; enable active low
   assign lin_txd_oe_n = ~txd_en_reg;
   assign lin_txd = txd_en_reg ? lin_txd_in : 1'b1;
endmodule

// >>> shared/xbrc_pkg.sv
// constants and types for the crossbar route control block
package xbrc_pkg;
   // three-level pin encoding: low, open/mid, high
   localparam logic [1:0] LVL_LOW = 2'h0;
   localparam logic [1:0] LVL_MID = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   // output selection code: input index or high impedance
   localparam logic [2:0] SEL_IN0 = 3'h0;
   localparam logic [2:0] SEL_IN1 = 3'h1;
   localparam logic [2:0] SEL_IN2 = 3'h2;
   localparam logic [2:0] SEL_IN3 = 3'h3;
   localparam logic [2:0] SEL_HIZ = 3'h4;
   localparam int NUM_OUT = 3;
   localparam int NUM_ROUTE_PINS = 6;
   // bus inactivity timeout default, in mclk cycles
   localparam int IDLE_TIMEOUT_CYC = 32'h0098_9680;
   localparam int IDLE_CNT_W = 24;
   typedef enum logic [1:0] {
      XBRC_LIN_SLEEP,
      XBRC_LIN_WAKE,
      XBRC_LIN_ACTIVE
   } xbrc_lin_state_t;
endpackage

// >>> design/xbrc_tri_decode.sv
// three-level pin decoder with synchronous sampling
module xbrc_tri_decode (
   input wire logic mclk,
   input wire logic rst,
   input wire logic pin_high,
   input wire logic pin_low,
   output logic [1:0] level
);
   // pad comparators give pin_high / pin_low; neither means open or mid bias
   wire logic [1:0] level_next;
   assign level_next = pin_high ? xbrc_pkg::LVL_HIGH :
                       pin_low ? xbrc_pkg::LVL_LOW : xbrc_pkg::LVL_MID;
   always_ff @(posedge mclk) begin
      if (rst) begin
         level <= xbrc_pkg::LVL_MID;
      end else begin
         level <= level_next;
      end
   end
endmodule

// >>> verif/xbrc_props.sv
// assertion checker for the crossbar route control block
module xbrc_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic pd_pin_high,
   input wire logic pd_pin_low,
   input wire logic route_wr,
   input wire logic [2:0] route_wr_out0,
   input wire logic [2:0] route_wr_out1,
   input wire logic [2:0] route_wr_out2,
   input wire logic preemph_wr,
   input wire logic preemph_wr_val,
   input wire logic sleep_cmd,
   input wire logic lin_rxd,
   input wire logic [2:0] out_port_0_sel,
   input wire logic [2:0] out_port_1_sel,
   input wire logic [2:0] out_port_2_sel,
   input wire logic preemph_en,
   input wire logic powerdown,
   input wire logic transceiver_sleep_n,
   input wire logic lin_txd_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   wire pd_mid = !pd_pin_high && !pd_pin_low;
   wire pd_low = !pd_pin_high && pd_pin_low;
   // rxd feeds the edge detect unsynchronised, so the fall is one sample back; two back is also accepted
   a_wake_on_fall: assert property ($rose(transceiver_sleep_n) |->
      ($past(lin_rxd, 2) && !$past(lin_rxd)) || ($past(lin_rxd, 3) && !$past(lin_rxd, 2)))
      else $error("sleep control rose without a receive fall");
   a_txd_after_wake: assert property ($fell(lin_txd_oe_n) |-> $past(transceiver_sleep_n))
      else $error("transmit enabled before wake");
   a_oe_needs_awake: assert property (!transceiver_sleep_n |-> lin_txd_oe_n)
      else $error("transmit enabled while transceiver sleeps");
   a_oe_follows_wake: assert property ($rose(transceiver_sleep_n) && !sleep_cmd |=>
      !lin_txd_oe_n) else $error("transmit not enabled after wake");
   a_sleep_cmd_drop: assert property (sleep_cmd |=> !transceiver_sleep_n)
      else $error("sleep command ignored");
   a_route_write: assert property (route_wr |=> out_port_0_sel == $past(route_wr_out0) &&
      out_port_1_sel == $past(route_wr_out1) && out_port_2_sel == $past(route_wr_out2))
      else $error("routing write not applied");
   a_pd_follows: assert property (!$past(rst) && !$past(rst, 2) |->
      powerdown == $past(pd_low, 2)) else $error("power-down does not follow pin");
   a_preemph_mid: assert property (!$past(rst) && !$past(rst, 2) && $past(pd_mid, 2) |->
      preemph_en) else $error("preemphasis not forced on");
   // setting lands one edge after the write, the output register one more
   a_preemph_write: assert property (!$past(rst) && preemph_wr && pd_pin_high &&
      $past(pd_pin_high) |-> ##2 preemph_en == $past(preemph_wr_val, 2))
      else $error("preemphasis write not applied");
   c_wake: cover property ($rose(transceiver_sleep_n));
   c_pd: cover property ($rose(powerdown));
   c_route_b2b: cover property (route_wr ##1 route_wr);
endmodule

bind xbrc_route_ctrl xbrc_props i_props (
   .mclk, .rst, .pd_pin_high, .pd_pin_low, .route_wr, .route_wr_out0, .route_wr_out1,
   .route_wr_out2, .preemph_wr, .preemph_wr_val, .sleep_cmd, .lin_rxd, .out_port_0_sel,
   .out_port_1_sel, .out_port_2_sel, .preemph_en, .powerdown, .transceiver_sleep_n,
   .lin_txd_oe_n
);

// >>> verif/xbrc_lin_xcvr.sv
// lin transceiver model: wake-up pulls receive low, transmit loops back
module xbrc_lin_xcvr (
   input wire logic mclk,
   input wire logic wake_req,
   input wire logic transceiver_sleep_n,
   input wire logic lin_txd,
   input wire logic lin_txd_oe_n,
   output logic lin_rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] low_reg = 3'h0;
   always_ff @(posedge mclk) begin
      if (wake_req)
         low_reg <= 3'h4;
      else if (low_reg != 3'h0)
         low_reg <= low_reg - 3'h1;
   end
   // pull-up idles the line high while the driver sleeps
   assign lin_rxd = (low_reg != 3'h0) ? 1'b0 :
                    (transceiver_sleep_n && !lin_txd_oe_n) ? lin_txd : 1'b1;
endmodule

// >>> verif/crossbar_route_control_tb.sv
// self-checking bench for the crossbar route control block
module crossbar_route_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, rst = 1'b1, small_variant = 1'b0, interface_select_pin = 1'b0;
   logic [5:0] route_pin_high = 6'h00, route_pin_low = 6'h00;
   logic pd_pin_high = 1'b1, pd_pin_low = 1'b0, route_wr = 1'b0, wake_req = 1'b0;
   logic [2:0] route_wr_out0 = 3'h0, route_wr_out1 = 3'h0, route_wr_out2 = 3'h0;
   logic preemph_wr = 1'b0, preemph_wr_val = 1'b0, sleep_cmd = 1'b0, lin_txd_in = 1'b1;
   logic lin_rxd, lin_mode, preemph_en, powerdown, transceiver_sleep_n, lin_txd, lin_txd_oe_n;
   logic [2:0] out_port_0_sel, out_port_1_sel, out_port_2_sel;
   int mismatches = 0, total_checks = 0, cycles = 0;
   // small, select, pins high, pins low, expected sels and lin mode
   logic [23:0] rows [8] = '{24'h04_e414, 24'h02_f0a0, 24'h01_e902, 24'h38_15c6,
      24'h38_0a38, 24'h00_0249, 24'h80_fe48, 24'hc0_fe49};
   initial forever #10 mclk = ~mclk;
   xbrc_route_ctrl #(.IDLE_TIMEOUT(20)) i_dut (.mclk, .rst, .small_variant,
      .interface_select_pin, .route_pin_high, .route_pin_low, .pd_pin_high, .pd_pin_low,
      .route_wr, .route_wr_out0, .route_wr_out1, .route_wr_out2, .preemph_wr, .preemph_wr_val,
      .sleep_cmd, .lin_rxd, .lin_txd_in, .lin_mode, .out_port_0_sel, .out_port_1_sel,
      .out_port_2_sel, .preemph_en, .powerdown, .transceiver_sleep_n, .lin_txd, .lin_txd_oe_n);
   xbrc_lin_xcvr i_xcvr (.mclk, .wake_req, .transceiver_sleep_n, .lin_txd, .lin_txd_oe_n,
      .lin_rxd);
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      // pins are latched only at power-up, so each row needs its own reset
      foreach (rows[i]) begin
         tick(1);
         {small_variant, interface_select_pin, route_pin_high, route_pin_low} <= rows[i][23:10];
         rst <= 1'b1;
         tick(3);
         rst <= 1'b0;
         tick(4);
         @(negedge mclk);
         chk({out_port_0_sel, out_port_1_sel, out_port_2_sel, lin_mode},
            rows[i][9:0]);
         chk({preemph_en, powerdown, transceiver_sleep_n, lin_txd_oe_n}, 16'h0001);
      end
      tick(1);
      route_wr <= 1'b1;
      {route_wr_out0, route_wr_out1, route_wr_out2} <= 9'h01c;
      tick(1);
      {route_wr_out0, route_wr_out1, route_wr_out2} <= 9'h088;
      tick(1);
      route_wr <= 1'b0;
      @(negedge mclk);
      chk({out_port_0_sel, out_port_1_sel, out_port_2_sel}, 16'h0088);
      tick(1);
      {preemph_wr, preemph_wr_val} <= 2'h3;
      tick(1);
      {preemph_wr, preemph_wr_val, pd_pin_high} <= 3'h4;
      tick(1);
      preemph_wr <= 1'b0;
      tick(2);
      @(negedge mclk);
      chk({preemph_en, powerdown}, 16'h0002);
      tick(1);
      pd_pin_low <= 1'b1;
      tick(3);
      @(negedge mclk);
      chk({powerdown, out_port_0_sel, out_port_1_sel, out_port_2_sel}, 16'h0288);
      tick(1);
      {pd_pin_high, pd_pin_low} <= 2'h2;
      tick(3);
      @(negedge mclk);
      chk({powerdown, preemph_en, out_port_0_sel, out_port_1_sel, out_port_2_sel},
         16'h0088);
      tick(1);
      wake_req <= 1'b1;
      tick(1);
      wake_req <= 1'b0;
      for (int k = 0; k < 10 && lin_txd_oe_n !== 1'b0; k++)
         tick(1);
      @(negedge mclk);
      chk({transceiver_sleep_n, lin_txd_oe_n}, 16'h0002);
      repeat (15) begin
         tick(2);
         lin_txd_in <= ~lin_txd_in;
      end
      @(negedge mclk);
      chk(transceiver_sleep_n, 16'h0001);
      tick(25);
      @(negedge mclk);
      chk({transceiver_sleep_n, lin_txd_oe_n}, 16'h0001);
      tick(1);
      {lin_txd_in, wake_req} <= 2'h3;
      tick(1);
      wake_req <= 1'b0;
      tick(6);
      sleep_cmd <= 1'b1;
      tick(1);
      sleep_cmd <= 1'b0;
      @(negedge mclk);
      chk({transceiver_sleep_n, lin_txd_oe_n}, 16'h0001);
      end_of_test();
   end
endmodule
